// ### fdl_pkg.sv
package fdl_pkg;

  localparam int TRIM_W      = 9;
  localparam int FRAC_W      = 8;
  localparam int ACC_W       = TRIM_W + FRAC_W;
  localparam int GAIN_W      = 4;
  localparam int BAND_W      = 3;
  localparam int REF_DIV_W   = 13;
  localparam int SETTLE_W    = 13;
  localparam int TOL_W       = 8;
  localparam int LIMIT_W     = 8;
  localparam int ODIV_W      = 2;
  localparam int CNT_DEF_W   = 18;
  localparam int CNT_MAX_W   = 24;
  localparam int ERR_W       = CNT_MAX_W + 1;
  localparam int IRQ_W       = 3;
  localparam int ADDR_W      = 5;

  localparam logic [ACC_W-1:0]  ACC_MAX       = 17'h1ffff;
  localparam logic [GAIN_W-1:0] GAIN_CODE_MAX = 4'hb;
  localparam logic [BAND_W-1:0] BAND_MAX      = 3'h4;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CFG_MAIN   = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_CFG_WINDOW = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_CFG_GAIN   = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_CFG_OSC    = 5'h0c;
  localparam logic [ADDR_W-1:0] OFS_STATUS     = 5'h10;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT   = 5'h14;
  localparam logic [ADDR_W-1:0] OFS_IRQ_CLR    = 5'h18;
  localparam logic [ADDR_W-1:0] OFS_IRQ_EN     = 5'h1c;

  // Field positions
  localparam int MAIN_TGT_LSB  = 0;
  localparam int MAIN_ODIV_LSB = 24;
  localparam int MAIN_EN_BIT   = 31;
  localparam int WIN_DIV_LSB   = 0;
  localparam int WIN_TOL_LSB   = 16;
  localparam int GAIN_I_LSB    = 0;
  localparam int GAIN_P_LSB    = 8;
  localparam int GAIN_SET_LSB  = 16;
  localparam int OSC_BAND_LSB  = 0;
  localparam int OSC_LIM_LSB   = 8;
  localparam int OSC_TRIM_LSB  = 16;
  localparam int ST_LOCK_BIT   = 0;
  localparam int ST_RUN_BIT    = 1;
  localparam int ST_TRIM_LSB   = 16;
  localparam int IRQ_LOCK_GAIN = 0;
  localparam int IRQ_LOCK_LOST = 1;
  localparam int IRQ_TRIM_SAT  = 2;

  // Masks and reset values
  localparam logic [31:0] WIN_MASK  = 32'h00ff_1fff;
  localparam logic [31:0] GAIN_MASK = 32'h1fff_0f0f;
  localparam logic [31:0] OSC_MASK  = 32'h01ff_ff07;
  localparam logic [31:0] RST_MAIN  = 32'h0100_0000;
  localparam logic [31:0] RST_WIN   = 32'h0001_0001;
  localparam logic [31:0] RST_GAIN  = 32'h0008_0808;
  localparam logic [31:0] RST_OSC   = 32'h0100_0000;

  typedef struct packed {
    logic signed [ERR_W-1:0] err;
    logic [GAIN_W-1:0]       igain;
    logic [GAIN_W-1:0]       pgain;
    logic [ACC_W-1:0]        acc;
    logic [LIMIT_W-1:0]      limit;
  } fdl_calc_in_s;

  typedef struct packed {
    logic [ACC_W-1:0] acc;
    logic             sat;
  } fdl_calc_out_s;

  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

endpackage

// ### fdl_trim_calc.sv
module fdl_trim_calc
  import fdl_pkg::*;
(
  input  wire fdl_calc_in_s  calc_in,
  output fdl_calc_out_s      calc_out
);

  localparam int DW = ERR_W + 13;

  // Gain code n scales by 2^(n-8), codes above 11 as code 11; trim keeps 8 fraction bits
  function automatic logic signed [DW-1:0] gain_term(
      input logic signed [ERR_W-1:0] e,
      input logic [GAIN_W-1:0]       code);
    logic [GAIN_W-1:0] c;
    c = (code > GAIN_CODE_MAX) ? GAIN_CODE_MAX : code;
    return DW'(e) <<< c;
  endfunction

  logic signed [DW-1:0] delta_raw;
  logic signed [DW-1:0] lim_fix;
  logic signed [DW-1:0] delta;
  logic signed [DW-1:0] sum;
  logic                 lim_on;

  assign delta_raw = gain_term(calc_in.err, calc_in.igain)
                   + gain_term(calc_in.err, calc_in.pgain);
  assign lim_fix = DW'({1'b0, calc_in.limit, {FRAC_W{1'b0}}});
  assign lim_on  = calc_in.limit != '0;
  assign delta = !lim_on ? delta_raw :
                 (delta_raw > lim_fix) ? lim_fix :
                 (delta_raw < -lim_fix) ? -lim_fix : delta_raw;
  assign sum = DW'({1'b0, calc_in.acc}) + delta;

  logic [ACC_W-1:0] acc_new;
  logic             sat_new;

  assign acc_new = (sum < 0) ? '0 :
                   (sum > DW'({1'b0, ACC_MAX})) ? ACC_MAX :
                   sum[ACC_W-1:0];
  assign sat_new = (sum < 0) || (sum > DW'({1'b0, ACC_MAX}));
  assign calc_out = '{acc: acc_new, sat: sat_new};

endmodule

// ### fdl_loop_ctrl.sv
module fdl_loop_ctrl
  import fdl_pkg::*;
#(
  parameter int CNT_W = CNT_DEF_W
) (
  input  wire logic               core_clk_in,
  input  wire logic               rst_b_in,
  input  wire logic [ADDR_W-1:0]  avs_address_in,
  input  wire logic               avs_read_in,
  input  wire logic               avs_write_in,
  input  wire logic [31:0]        avs_writedata_in,
  input  wire logic [3:0]         avs_byteenable_in,
  output logic      [31:0]        avs_readdata_out,
  output logic                    avs_waitrequest_out,
  input  wire logic               ref_clk_in,
  input  wire logic               osc_clk_in,
  output logic      [TRIM_W-1:0]  osc_trim_out,
  output logic      [BAND_W-1:0]  osc_band_out,
  output logic                    loop_clk_out,
  output logic                    lock_out,
  output logic                    irq_out
);

  if (CNT_W < TOL_W || CNT_W > CNT_MAX_W) begin : g_bad_cnt
    $error("CNT_W out of supported range");
  end

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ALIGN,
    ST_COUNT,
    ST_SETTLE
  } fdl_state_e;

  localparam logic [31:0] MAIN_MASK = (32'h1 << MAIN_EN_BIT)
                                    | (32'h3 << MAIN_ODIV_LSB)
                                    | ((32'h1 << CNT_W) - 32'h1);

  localparam logic [ACC_W-1:0] ACC_RST =
    {RST_OSC[OSC_TRIM_LSB +: TRIM_W], {FRAC_W{1'b0}}};

  // Whole trim steps of the accumulator
  function automatic logic [TRIM_W-1:0] trim_of(input logic [ACC_W-1:0] a);
    return a[ACC_W-1 -: TRIM_W];
  endfunction

  // Bus and register state
  logic [31:0]        main_q;
  logic [31:0]        win_q;
  logic [31:0]        gain_q;
  logic [31:0]        osc_q;
  logic [IRQ_W-1:0]   irq_stat_q;
  logic [IRQ_W-1:0]   irq_stat_d;
  logic [IRQ_W-1:0]   irq_en_q;
  logic               wait_q;
  logic [31:0]        rdata_q;

  // Loop state
  fdl_state_e         state_q;
  fdl_state_e         state_d;
  logic               ref_prev_q;
  logic               osc_prev_q;
  logic [REF_DIV_W-1:0] ref_cnt_q;
  logic [REF_DIV_W-1:0] ref_cnt_d;
  logic [CNT_W-1:0]   osc_cnt_q;
  logic [CNT_W-1:0]   osc_cnt_d;
  logic [ACC_W-1:0]   acc_q;
  logic [ACC_W-1:0]   acc_d;
  logic               lock_q;
  logic               lock_d;
  logic               div2_q;

  // Bus decode
  wire logic          bus_req   = avs_read_in | avs_write_in;
  wire logic          bus_acc   = bus_req & ~wait_q;
  wire logic          wr_acc    = avs_write_in & bus_acc;
  wire logic          wr_main   = wr_acc & (avs_address_in == OFS_CFG_MAIN);
  wire logic          wr_win    = wr_acc & (avs_address_in == OFS_CFG_WINDOW);
  wire logic          wr_gain   = wr_acc & (avs_address_in == OFS_CFG_GAIN);
  wire logic          wr_osc    = wr_acc & (avs_address_in == OFS_CFG_OSC);
  wire logic          wr_clr    = wr_acc & (avs_address_in == OFS_IRQ_CLR);
  wire logic          wr_ien    = wr_acc & (avs_address_in == OFS_IRQ_EN);
  wire logic [31:0]   wdata     = avs_writedata_in;
  wire logic [3:0]    be        = avs_byteenable_in;
  wire logic [31:0]   osc_merge = be_merge(osc_q, wdata, be);
  wire logic [BAND_W-1:0] band_wr = osc_merge[OSC_BAND_LSB +: BAND_W];
  wire logic [BAND_W-1:0] band_ok =
    (band_wr > BAND_MAX) ? BAND_MAX : band_wr;
  wire logic [31:0]   osc_wr_val =
    {osc_merge[31:OSC_BAND_LSB+BAND_W], band_ok} & OSC_MASK;
  wire logic [31:0]   clr_word  = be_merge(32'h0, wdata, be);
  wire logic [31:0]   status_word =
    (32'(trim_of(acc_q)) << ST_TRIM_LSB)
    | (32'(state_q != ST_IDLE) << ST_RUN_BIT)
    | (32'(lock_q) << ST_LOCK_BIT);
  wire logic [31:0]   osc_rd =
    (osc_q & ~(32'h1ff << OSC_TRIM_LSB))
    | (32'(trim_of(acc_q)) << OSC_TRIM_LSB);
  wire logic [31:0]   rd_mux =
    (avs_address_in == OFS_CFG_MAIN)   ? main_q :
    (avs_address_in == OFS_CFG_WINDOW) ? win_q :
    (avs_address_in == OFS_CFG_GAIN)   ? gain_q :
    (avs_address_in == OFS_CFG_OSC)    ? osc_rd :
    (avs_address_in == OFS_STATUS)     ? status_word :
    (avs_address_in == OFS_IRQ_STAT)   ? 32'(irq_stat_q) :
    (avs_address_in == OFS_IRQ_EN)     ? 32'(irq_en_q) : 32'h0;

  // Config fields
  wire logic              enable   = main_q[MAIN_EN_BIT];
  wire logic [CNT_W-1:0]  target   = main_q[MAIN_TGT_LSB +: CNT_W];
  wire logic [REF_DIV_W-1:0] ref_div = win_q[WIN_DIV_LSB +: REF_DIV_W];
  wire logic [REF_DIV_W-1:0] div_eff =
    (ref_div == '0) ? REF_DIV_W'(1) : ref_div;
  wire logic [TOL_W-1:0]  tol      = win_q[WIN_TOL_LSB +: TOL_W];
  wire logic [SETTLE_W-1:0] settle = gain_q[GAIN_SET_LSB +: SETTLE_W];

  // Edge detection on synchronous reference and oscillator inputs
  wire logic ref_rise = ref_clk_in & ~ref_prev_q;
  wire logic osc_rise = osc_clk_in & ~osc_prev_q;
  wire logic [REF_DIV_W:0] ref_cnt_inc = {1'b0, ref_cnt_q} + 1'b1;
  wire logic win_done = (state_q == ST_COUNT) & ref_rise
                      & (ref_cnt_inc >= {1'b0, div_eff});
  wire logic settle_done = ref_rise
    & (ref_cnt_inc >= {1'b0, settle});
  wire logic osc_full = &osc_cnt_q;
  wire logic [CNT_W-1:0] osc_cnt_inc =
    (osc_rise & ~osc_full) ? osc_cnt_q + 1'b1 : osc_cnt_q;

  // Error and lock check
  logic signed [CNT_W:0] err_w;
  logic        [CNT_W:0] err_mag;
  assign err_w = $signed({1'b0, target})
               - $signed({1'b0, osc_cnt_inc});
  assign err_mag = (err_w < 0) ? CNT_W'(0) - err_w : err_w;
  wire logic meas_lock =
    err_mag < {{(CNT_W+1-TOL_W){1'b0}}, tol};

  fdl_calc_in_s  calc_in;
  fdl_calc_out_s calc_out;
  assign calc_in = '{
    err:   ERR_W'(err_w),
    igain: gain_q[GAIN_I_LSB +: GAIN_W],
    pgain: gain_q[GAIN_P_LSB +: GAIN_W],
    acc:   acc_q,
    limit: osc_q[OSC_LIM_LSB +: LIMIT_W]
  };

  fdl_trim_calc u_calc (
    .calc_in  (calc_in),
    .calc_out (calc_out)
  );

  // Loop sequencing
  always_comb begin
    state_d   = state_q;
    ref_cnt_d = ref_cnt_q;
    osc_cnt_d = osc_cnt_inc;
    unique case (state_q)
      ST_IDLE: begin
        if (enable) begin
          state_d = ST_ALIGN;
        end
      end
      ST_ALIGN: begin
        ref_cnt_d = '0;
        osc_cnt_d = '0;
        if (ref_rise) begin
          state_d = ST_COUNT;
        end
      end
      ST_COUNT: begin
        if (ref_rise) begin
          ref_cnt_d = ref_cnt_inc[REF_DIV_W-1:0];
        end
        if (win_done) begin
          ref_cnt_d = '0;
          osc_cnt_d = '0;
          state_d = (settle == '0) ? ST_COUNT : ST_SETTLE;
        end
      end
      ST_SETTLE: begin
        osc_cnt_d = '0;
        if (ref_rise) begin
          ref_cnt_d = ref_cnt_inc[REF_DIV_W-1:0];
        end
        if (settle_done) begin
          ref_cnt_d = '0;
          state_d = ST_COUNT;
        end
      end
    endcase
    if (!enable) begin
      state_d = ST_IDLE;
    end
  end

  assign acc_d = wr_osc ?
    {osc_wr_val[OSC_TRIM_LSB +: TRIM_W], {FRAC_W{1'b0}}} :
    win_done ? calc_out.acc : acc_q;
  assign lock_d = !enable ? 1'b0 : win_done ? meas_lock : lock_q;

  // Sticky events; a set in the clearing cycle survives
  wire logic [IRQ_W-1:0] irq_ev =
    {win_done & calc_out.sat,
     win_done & lock_q & ~meas_lock,
     win_done & ~lock_q & meas_lock};
  assign irq_stat_d = (irq_stat_q & ~(wr_clr ? clr_word[IRQ_W-1:0] : '0))
                    | irq_ev;

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= ~(bus_req & wait_q);
    end
  end

  // Read data captured in the waitrequest cycle before the accepting cycle
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rdata_q <= 32'h0;
    end else if (avs_read_in & wait_q) begin
      rdata_q <= rd_mux;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      main_q   <= RST_MAIN;
      win_q    <= RST_WIN;
      gain_q   <= RST_GAIN;
      osc_q    <= RST_OSC;
      irq_en_q <= '0;
    end else begin
      if (wr_main) main_q <= be_merge(main_q, wdata, be) & MAIN_MASK;
      if (wr_win)  win_q  <= be_merge(win_q, wdata, be) & WIN_MASK;
      if (wr_gain) gain_q <= be_merge(gain_q, wdata, be) & GAIN_MASK;
      if (wr_osc)  osc_q  <= osc_wr_val;
      if (wr_ien)  irq_en_q <= be_merge(32'(irq_en_q), wdata, be)
                               [IRQ_W-1:0];
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ref_prev_q <= 1'b0;
      osc_prev_q <= 1'b0;
    end else begin
      ref_prev_q <= ref_clk_in;
      osc_prev_q <= osc_clk_in;
    end
  end

  // Window sequencing state
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_q   <= ST_IDLE;
      ref_cnt_q <= '0;
      osc_cnt_q <= '0;
    end else begin
      state_q   <= state_d;
      ref_cnt_q <= ref_cnt_d;
      osc_cnt_q <= osc_cnt_d;
    end
  end

  // Trim accumulator and lock flag
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      acc_q  <= ACC_RST;
      lock_q <= 1'b0;
    end else begin
      acc_q  <= acc_d;
      lock_q <= lock_d;
    end
  end

  // Sticky status and interrupt line
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      irq_stat_q <= '0;
      irq_out    <= 1'b0;
    end else begin
      irq_stat_q <= irq_stat_d;
      irq_out    <= |(irq_stat_d & irq_en_q);
    end
  end

  // Output clock at half the oscillator rate while enabled, held when disabled
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      div2_q <= 1'b0;
    end else if (enable & osc_rise) begin
      div2_q <= ~div2_q;
    end
  end

  assign avs_readdata_out    = rdata_q;
  assign avs_waitrequest_out = wait_q;
  assign osc_trim_out        = trim_of(acc_q);
  assign osc_band_out        = osc_q[OSC_BAND_LSB +: BAND_W];
  assign loop_clk_out        = div2_q;
  assign lock_out            = lock_q;

endmodule

// ### fdl_loop_ctrl_chk.sv
module fdl_loop_ctrl_chk
  import fdl_pkg::*;
#(
  parameter int CNT_W = CNT_DEF_W
) (
  input wire logic              core_clk_in,
  input wire logic              rst_b_in,
  input wire logic [ADDR_W-1:0] avs_address_in,
  input wire logic              avs_read_in,
  input wire logic              avs_write_in,
  input wire logic [31:0]       avs_writedata_in,
  input wire logic [3:0]        avs_byteenable_in,
  input wire logic [31:0]       avs_readdata_out,
  input wire logic              avs_waitrequest_out,
  input wire logic              ref_clk_in,
  input wire logic              osc_clk_in,
  input wire logic [TRIM_W-1:0] osc_trim_out,
  input wire logic [BAND_W-1:0] osc_band_out,
  input wire logic              loop_clk_out,
  input wire logic              lock_out,
  input wire logic              irq_out
);
  logic              en_q;
  logic              ref_p_q;
  logic [2:0]        since_q;
  logic [2:0]        irq_en_q;
  logic [BAND_W-1:0] band_q;
  logic [TRIM_W-1:0] trim_q;
  wire               acc_wr = avs_write_in && !avs_waitrequest_out;
  wire               wr_osc = acc_wr && avs_address_in == OFS_CFG_OSC;
  wire               wr_main = acc_wr && avs_address_in == OFS_CFG_MAIN
                               && avs_byteenable_in[3];
  wire               wr_ien = acc_wr && avs_address_in == OFS_IRQ_EN
                              && avs_byteenable_in[0];
  wire [2:0]         band_w = (avs_writedata_in[2:0] > BAND_MAX) ?
                              BAND_MAX : avs_writedata_in[2:0];
  wire               ref_rise = ref_clk_in && !ref_p_q;

  // Mirrors of enable, irq enable and written osc fields
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      en_q     <= 1'b0;
      ref_p_q  <= 1'b0;
      since_q  <= 3'h0;
      irq_en_q <= 3'h0;
      band_q   <= 3'h0;
      trim_q   <= 9'h100;
    end else begin
      ref_p_q <= ref_clk_in;
      if (wr_main) en_q <= avs_writedata_in[MAIN_EN_BIT];
      if (wr_ien) irq_en_q <= avs_writedata_in[2:0];
      if (wr_osc && avs_byteenable_in[0]) band_q <= band_w;
      if (wr_osc) trim_q <= avs_writedata_in[24:16];
      if (ref_rise || wr_osc) since_q <= 3'h0;
      else if (since_q != 3'h7) since_q <= since_q + 3'h1;
    end
  end

  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_b_in);

  sequence s_req;
    (avs_read_in || avs_write_in) && avs_waitrequest_out;
  endsequence
  sequence s_band_wr;
    wr_osc && avs_byteenable_in[0];
  endsequence
  sequence s_trim_wr;
    wr_osc && avs_byteenable_in[3:2] == 2'h3 && !en_q;
  endsequence

  AST_WAIT_ONE: assert property (s_req |=> !avs_waitrequest_out
    ##1 avs_waitrequest_out) else $error("waitrequest not one cycle");
  AST_WAIT_IDLE: assert property (!avs_read_in && !avs_write_in &&
    avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("waitrequest dropped without request");
  AST_BAND_WR: assert property (s_band_wr |-> ##2 osc_band_out == band_q)
    else $error("band output not clamped write");
  AST_BAND_MAX: assert property (osc_band_out <= BAND_MAX)
    else $error("band output above four");
  AST_TRIM_LOAD: assert property (s_trim_wr |-> ##2 osc_trim_out == trim_q)
    else $error("trim not loaded from write");
  AST_TRIM_CAUSE: assert property ($changed(osc_trim_out) |-> since_q < 3'h6)
    else $error("trim changed without window end");
  AST_LOCK_OFF: assert property (wr_main && !avs_writedata_in[MAIN_EN_BIT]
    |-> ##2 !lock_out) else $error("lock kept after disable");
  AST_LOOP_IDLE: assert property (!en_q [*4] |=> $stable(loop_clk_out))
    else $error("loop clock toggles while disabled");
  AST_LOOP_OSC: assert property ($stable(osc_clk_in) [*5]
    |=> $stable(loop_clk_out)) else $error("loop clock without osc edge");
  AST_IRQ_OFF: assert property (irq_en_q == 3'h0 && $past(irq_en_q) == 3'h0
    |-> !irq_out) else $error("irq high with all sources masked");
endmodule

bind fdl_loop_ctrl fdl_loop_ctrl_chk #(.CNT_W(CNT_W)) u_chk (
  .core_clk_in(core_clk_in), .rst_b_in(rst_b_in),
  .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
  .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
  .avs_byteenable_in(avs_byteenable_in),
  .avs_readdata_out(avs_readdata_out),
  .avs_waitrequest_out(avs_waitrequest_out), .ref_clk_in(ref_clk_in),
  .osc_clk_in(osc_clk_in), .osc_trim_out(osc_trim_out),
  .osc_band_out(osc_band_out), .loop_clk_out(loop_clk_out),
  .lock_out(lock_out), .irq_out(irq_out));

// ### fdl_loop_ctrl_bench.sv
`define CHK(n, e, g) chk(n, 32'(e), 32'(g))
module fdl_loop_ctrl_bench
  import fdl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0, rst_b = 1'b0, rd = 1'b0, wr = 1'b0;
  logic        ref_c = 1'b0, osc_c = 1'b0, osc_run = 1'b0;
  logic [4:0]  addr = 5'h00;
  logic [3:0]  be = 4'hf;
  logic [31:0] wd = 32'h0, rdat, w;
  wire  [31:0] rdata;
  wire  [8:0]  trim;
  wire  [2:0]  band;
  wire         wreq, lclk, lock, irq;
  int          n_fail = 0, total_checks = 0, cyc = 0, k, d, e;
  logic [4:0]  ra [8] = '{5'h00, 5'h04, 5'h08, 5'h0c, 5'h10, 5'h14,
                          5'h18, 5'h1c};
  logic [31:0] rv [8] = '{RST_MAIN, RST_WIN, RST_GAIN, RST_OSC,
                          32'h0100_0000, 32'h0, 32'h0, 32'h0};

  fdl_loop_ctrl #(.CNT_W(12)) dut (.core_clk_in(clk), .rst_b_in(rst_b),
    .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr),
    .avs_writedata_in(wd), .avs_byteenable_in(be),
    .avs_readdata_out(rdata), .avs_waitrequest_out(wreq),
    .ref_clk_in(ref_c), .osc_clk_in(osc_c), .osc_trim_out(trim),
    .osc_band_out(band), .loop_clk_out(lclk), .lock_out(lock),
    .irq_out(irq));

  always #2 clk = ~clk;
  // Ref rises every 32 cycles, osc every 4, never in the same cycle
  always @(posedge clk) begin
    cyc <= cyc + 1;
    ref_c <= (cyc[4:0] + 5'd8) >= 5'd16;
    if (osc_run) osc_c <= cyc[1];
    if (cyc == 40000) begin
      n_fail++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    if (n_fail == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(string n, logic [31:0] ex, logic [31:0] g);
    total_checks++;
    if (g !== ex) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", n, ex, g);
    end
  endtask

  task automatic bus(logic wn, logic [4:0] a, logic [31:0] dv);
    @(posedge clk);
    rd <= !wn;
    wr <= wn;
    addr <= a;
    wd <= dv;
    do @(posedge clk); while (wreq !== 1'b0);
    rdat = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic wrr(logic [4:0] a, logic [31:0] dv);
    bus(1'b1, a, dv);
  endtask

  task automatic rdc(string n, logic [4:0] a, logic [31:0] ex);
    bus(1'b0, a, 32'h0);
    `CHK(n, ex, rdat);
  endtask

  function automatic int nxt(int t, int er, int i, int p, int lim);
    int dl;
    dl = er * ((1 << (i - 8)) + (1 << (p - 8)));
    if (lim != 0 && dl > lim) dl = lim;
    if (lim != 0 && dl < -lim) dl = -lim;
    t = t + dl;
    return (t > 511) ? 511 : ((t < 0) ? 0 : t);
  endfunction

  task automatic wait_trim(output int t);
    logic [8:0] o;
    int         n;
    o = trim;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (trim === o && n < 2000);
    t = cyc;
  endtask

  task automatic run(int dv, int s, int er, int i, int p, int tol, int lim,
                     int t0);
    int t1, t2, a, b;
    bit lk, st;
    logic l0;
    t1 = nxt(t0, er, i, p, lim);
    t2 = nxt(t1, er, i, p, lim);
    lk = ((er < 0) ? -er : er) < tol;
    st = (t1 == 511) || (t1 == 0);
    wrr(OFS_CFG_MAIN, 32'h0);
    wrr(OFS_IRQ_CLR, 32'h7);
    wrr(OFS_CFG_WINDOW, {8'h0, 8'(tol), 3'h0, 13'(dv)});
    wrr(OFS_CFG_GAIN, {3'h0, 13'(s), 4'h0, 4'(p), 4'h0, 4'(i)});
    wrr(OFS_CFG_OSC, {7'h0, 9'(t0), 8'(lim), 8'h0});
    wrr(OFS_IRQ_EN, 32'h7);
    wrr(OFS_CFG_MAIN, 32'h8100_0000 | 32'(8 * dv + er));
    wait_trim(a);
    `CHK("trim_first", t1, trim);
    `CHK("lock", lk, lock);
    `CHK("irq", lk | st, irq);
    rdc("irq_stat", OFS_IRQ_STAT, {st, 1'b0, lk});
    rdc("status", OFS_STATUS, {7'h0, 9'(t1), 14'h0, 1'b1, lk});
    l0 = lclk;
    repeat (4) @(negedge clk);
    `CHK("loop_clk", !l0, lclk);
    if (t2 != t1) begin
      wait_trim(b);
      `CHK("trim_second", t2, trim);
      `CHK("interval", 32 * (dv + s), b - a);
    end
  endtask

  initial begin
    k = $urandom(32'h06238794);
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(negedge clk);
    `CHK("trim_rst", 9'h100, trim);
    `CHK("wait_rst", 1'b1, wreq);
    `CHK("out_rst", 6'h0, {band, lock, lclk, irq});
    wrr(OFS_STATUS, 32'hffff_ffff);
    wrr(OFS_IRQ_STAT, 32'hffff_ffff);
    for (int j = 0; j < 8; j++) rdc("reg_rst", ra[j], rv[j]);
    for (int j = 0; j < 4; j++) begin
      w = $urandom;
      wrr(OFS_CFG_GAIN, w);
      rdc("gain", OFS_CFG_GAIN, w & GAIN_MASK);
      wrr(OFS_CFG_WINDOW, w);
      rdc("window", OFS_CFG_WINDOW, w & WIN_MASK);
      wrr(OFS_CFG_MAIN, w & 32'h0300_0fff);
      rdc("main", OFS_CFG_MAIN, w & 32'h0300_0fff);
      wrr(OFS_CFG_OSC, w);
      repeat (2) @(negedge clk);
      w[2:0] = (w[2:0] > 3'h4) ? 3'h4 : w[2:0];
      `CHK("band", w[2:0], band);
      `CHK("trim_load", w[24:16], trim);
      rdc("osc", OFS_CFG_OSC, w & OSC_MASK);
    end
    osc_run <= 1'b1;
    run(1, 0, 3, 8, 8, 4, 0, 256);
    run(2, 8, -4, 8, 9, 4, 0, 256);
    run(19, 2, 6, 8, 8, 1, 0, 510);
    wrr(OFS_IRQ_EN, 32'h0);
    repeat (2) @(negedge clk);
    `CHK("irq_masked", 1'b0, irq);
    wrr(OFS_IRQ_EN, 32'h4);
    repeat (2) @(negedge clk);
    `CHK("irq_sat", 1'b1, irq);
    wrr(OFS_CFG_MAIN, 32'h0);
    wrr(OFS_IRQ_CLR, 32'h7);
    repeat (2) @(negedge clk);
    `CHK("irq_clr", 1'b0, irq);
    run(3, 0, 5, 8, 8, 9, 1, 300);
    for (int j = 0; j < 5; j++) begin
      d = 1 + $urandom % 3;
      e = 1 + $urandom % 6;
      if ($urandom % 2) e = -e;
      run(d, $urandom % 3, e, 8 + $urandom % 3, 8 + $urandom % 3,
          1 + $urandom % 8, 0, 256);
    end
    report_and_stop();
  end
endmodule
